// file: test/tb.sv
// Purpose: Self-checking bench for the receive system-side output block.
// Assumes: Line clock 160 ns, backplane model clock 128 ns, core clock 10 ns.
// Notes: A walk of bit and frame counters predicts every output except framer data at each tick.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import trx_pkg::*;

  logic core_clk, line_clk, rstn = 1'h0, es = 1'h0, msel = 1'h0, dbl = 1'h1, sin = 1'h0;
  logic fr_valid = 1'h0, fr_bit = 1'h0, fr_sig = 1'h0, link_bit = 1'h0, sync_req = 1'h0;
  logic stall = 1'h0, stall_bit = 1'h0, started = 1'h0, bp_run = 1'h0, use_bp = 1'h0;
  trx_format_type fmt = TRX_FMT_D4;
  logic [23:0] mask = 24'hA5C396;
  logic ready, fdo, ser, sig, chclk, chblk, fp, mp, bs_o, bs_oe, ldat, lclk;
  wire logic bp_clk, bp_sync, bs_pin;
  int bitn = 192, frm = 11, mf = 12, cyc = 0, mismatches = 0, tests_run = 0;
  logic fknown = 1'h1, lk = 1'h1, elclk = 1'h0, eldat = 1'h0, eser = 1'h0, esig = 1'h0;
  logic emsel = 1'h0, edbl = 1'h1, ebs;
  trx_format_type ef = TRX_FMT_D4;
  logic [1:0] pq[$];
  logic [7:0] pcnt = 8'h00;

  // Whoever has the output enable owns the shared boundary sync wire.
  assign bs_pin = bs_oe ? bs_o : bp_sync;

  trx_rx_system i_trx_rx_system (
    .core_clk_i(core_clk),
    .rstn_i(rstn),
    .recv_line_clk_i(line_clk),
    .recv_backplane_clock_i(bp_clk),
    .recv_elastic_store_enable_i(es),
    .recv_format_i(fmt),
    .sync_multiframe_select_i(msel),
    .sync_double_wide_enable_i(dbl),
    .sync_input_enable_i(sin),
    .recv_channel_block_mask_i(mask),
    .recv_framer_valid_i(fr_valid),
    .recv_framer_bit_i(fr_bit),
    .recv_framer_sig_i(fr_sig),
    .recv_link_bit_i(link_bit),
    .recv_boundary_sync_i(bs_pin),
    .recv_framer_ready_o(ready),
    .recv_framer_data_out_o(fdo),
    .recv_serial_out_o(ser),
    .recv_signaling_out_o(sig),
    .recv_channel_clock_out_o(chclk),
    .recv_channel_block_out_o(chblk),
    .recv_frame_pulse_o(fp),
    .recv_multiframe_pulse_o(mp),
    .recv_boundary_sync_o(bs_o),
    .recv_boundary_sync_oe_o(bs_oe),
    .recv_link_data_out_o(ldat),
    .recv_link_clock_out_o(lclk)
  );

  trx_backplane_model i_trx_backplane_model (
    .run_i(bp_run),
    .sync_req_i(sync_req),
    .bp_clk_o(bp_clk),
    .sync_o(bp_sync)
  );

  // Core clock.
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // Line clock starts after reset and never lines up with a core edge.
  initial begin
    line_clk = 1'h0;
    #403;
    forever #80 line_clk = ~line_clk;
  end

  // Framer feeder: logs every accepted word so the pop order can be predicted.
  always @(posedge core_clk) begin
    if (fr_valid === 1'h1 && ready === 1'h1) begin
      pq.push_back({fr_sig, fr_bit});
      pcnt++;
    end
    fr_bit <= stall ? stall_bit : pcnt[0] ^ pcnt[2];
    fr_sig <= pcnt[1];
    fr_valid <= started & ~stall;
  end

  // Hang guard, well above the planned run of about 69000 cycles.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      $display("unexpected run length: expected under 90000 cycles, seen %0d", cyc);
      tally_and_finish();
    end
  end

  task automatic chk(input string name, input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b, seen %b", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One bit time: wait for the active clock, let the outputs settle, compare.
  task automatic tick();
    int g;
    logic lf;
    if (use_bp) @(posedge bp_clk);
    else @(posedge line_clk);
    repeat (7) @(posedge core_clk);
    @(negedge core_clk);
    bitn = (bitn == 192) ? 0 : bitn + 1;
    if (bitn == 0) begin
      frm = (frm + 1) % mf;
      ef = fmt;
      emsel = msel;
      edbl = dbl;
      mf = (ef == TRX_FMT_D4) ? 12 : 24;
    end
    // Link outputs move one bit time ahead of the frame that they serve.
    if (bitn == 192 && fknown) begin
      g = (frm + 1) % mf;
      lf = (ef == TRX_FMT_D4) ? g[0] : (ef == TRX_FMT_ESF) ? !g[0] : (g % 4 == 0);
      elclk = (ef == TRX_FMT_ZBTSI) ? (g % 4 < 2) : lf;
      if (lf) begin
        eldat = link_bit;
        lk = 1'h1;
      end
    end
    if (pq.size() > 0) {esig, eser} = pq.pop_front();
    chk("serial", ser, eser);
    chk("signaling", sig, esig);
    chk("ready", ready, pq.size() < 2);
    chk("frame_pulse", fp, bitn == 0);
    chk("chan_clock", chclk, bitn != 0 && bitn % 8 == 0);
    chk("chan_block", chblk, bitn != 0 && mask[(bitn - 1) / 8]);
    chk("sync_oe", bs_oe, !(es && sin));
    if (fknown) chk("mframe_pulse", mp, bitn == 0 && frm == 0);
    ebs = emsel ? (bitn == 0 && frm == 0) : (bitn == 0 || (edbl && bitn == 1 && frm % 6 == 5));
    if (es && sin) chk("sync_out", bs_o, 1'h0);
    else if (fknown) chk("sync_out", bs_o, ebs);
    if (lk) chk("link_clock", lclk, elclk);
    if (lk) chk("link_data", ldat, eldat);
    @(posedge core_clk);
    // A new link bit is offered at each frame start, on a rising core edge.
    if (bitn == 0) link_bit <= ~link_bit;
  endtask

  task automatic frames(input int n);
    repeat (n) begin
      do tick(); while (bitn != 0);
    end
  endtask

  // Switching back parks the backplane clock first, so no backplane tick goes unseen,
  // then waits for a low line clock, so no line tick is in flight.
  // The domain flag is blocking so the very next tick already waits on the new clock.
  task automatic switch_domain(input logic to_bp);
    if (!to_bp) begin
      bp_run <= 1'h0;
      @(negedge line_clk);
    end
    @(posedge core_clk);
    es <= to_bp;
    if (to_bp) bp_run <= 1'h1;
    use_bp = to_bp;
    bitn = 192;
    fknown = 1'h0;
    lk = 1'h0;
  endtask

  // Main sequence: line timing in D4, then backplane timing in ESF and ZBTSI.
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk("ready_rst", ready, 1'h1);
    chk("oe_rst", bs_oe, 1'h1);
    chk("frame_rst", fp, 1'h0);
    chk("serial_rst", ser, 1'h0);
    @(posedge core_clk);
    started <= 1'h1;
    frames(1);
    stall <= 1'h1;
    stall_bit <= 1'h1;
    repeat (5) tick();
    chk("framer_data", fdo, 1'h1);
    stall <= 1'h0;
    frames(12);
    msel <= 1'h1;
    frames(2);
    fmt <= TRX_FMT_ESF;
    sin <= 1'h1;
    switch_domain(1'h1);
    repeat (3) tick();
    sync_req <= 1'h1;
    bitn = 192;
    frm = 23;
    fknown = 1'h1;
    tick();
    sync_req <= 1'h0;
    frames(2);
    sin <= 1'h0;
    stall <= 1'h1;
    stall_bit <= 1'h0;
    repeat (5) tick();
    chk("framer_data", fdo, 1'h0);
    stall <= 1'h0;
    frames(2);
    fmt <= TRX_FMT_ZBTSI;
    frames(5);
    switch_domain(1'h0);
    frames(2);
    tally_and_finish();
  end
endmodule

// file: test/trx_backplane_model.sv
// Purpose: Backplane-side model: system clock and boundary sync pulse source.
// Assumes: run_i is high only while the block uses its elastic store.
// Notes: A 128 ns period stands for a burst clock below the 8.192 MHz ceiling.
module trx_backplane_model (
  input wire logic run_i,
  input wire logic sync_req_i,
  output logic bp_clk_o,
  output logic sync_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // The clock parks low when unused, so no stray edge reaches the block.
  initial begin
    bp_clk_o = 1'h0;
    forever begin
      #64;
      bp_clk_o = run_i ? ~bp_clk_o : 1'h0;
    end
  end

  // The pulse is long enough for the block's pin synchroniser to see it.
  initial begin
    sync_o = 1'h0;
    forever begin
      @(posedge sync_req_i);
      sync_o = 1'h1;
      #40;
      sync_o = 1'h0;
    end
  end
endmodule

// file: verilog/trx_bit_buffer.sv
// Purpose: Small FIFO between the framer side and the system-side timing.
// Assumes: Push and pop run on the same core clock.
// Notes: in_ready_o is a flop, so the framer sees a clean stall signal.
`include "trx_defs.svh"
module trx_bit_buffer #(
  parameter int WIDTH = `TRX_BUF_WIDTH,
  parameter int DEPTH = `TRX_BUF_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] count;
    logic in_ready;
  } trx_buf_type;

  trx_buf_type s_ff;
  trx_buf_type nxt_s;
  logic push;
  logic pop;

  // Pointers wrap at DEPTH; the count alone tells full from empty.
  always_comb begin
    nxt_s = s_ff;
    push = in_valid_i & s_ff.in_ready;
    pop = out_ready_i & (s_ff.count != '0);
    if (push) begin
      nxt_s.mem[s_ff.wr] = in_data_i;
      nxt_s.wr = (s_ff.wr == PW'(DEPTH - 1)) ? '0 : PW'(s_ff.wr + 1'b1);
    end
    if (pop) begin
      nxt_s.rd = (s_ff.rd == PW'(DEPTH - 1)) ? '0 : PW'(s_ff.rd + 1'b1);
    end
    nxt_s.count = CW'(s_ff.count + CW'(push) - CW'(pop));
    nxt_s.in_ready = (nxt_s.count != CW'(DEPTH));
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
      s_ff.in_ready <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign in_ready_o = s_ff.in_ready;
  assign out_valid_o = (s_ff.count != '0);
  assign out_data_o = s_ff.mem[s_ff.rd];
endmodule

// file: verilog/trx_defs.svh
// Purpose: Shared constants of the receive system-side output block.
// Assumes: Included by the package and by the top module.
// Notes: Frame positions count the F bit as bit 0, channel bits as 1 to 192.
`ifndef TRX_DEFS_SVH
`define TRX_DEFS_SVH
`define TRX_FBIT 8'h00
`define TRX_FIRST_CHAN_BIT 8'h01
`define TRX_LAST_BIT 8'hC0
`define TRX_LSB_SLOT 3'h0
`define TRX_D4_LAST_FRAME 5'h0B
`define TRX_ESF_LAST_FRAME 5'h17
`define TRX_SIG_FRAME_A 5'h05
`define TRX_SIG_FRAME_B 5'h0B
`define TRX_SIG_FRAME_C 5'h11
`define TRX_SIG_FRAME_D 5'h17
`define TRX_FRAME_KHZ 8
`define TRX_LINK_KHZ 4
`define TRX_ZBTSI_LINK_KHZ 2
`define TRX_LINK_FRAMES 5'(`TRX_FRAME_KHZ / `TRX_LINK_KHZ)
`define TRX_ZBTSI_LINK_FRAMES 5'(`TRX_FRAME_KHZ / `TRX_ZBTSI_LINK_KHZ)
`define TRX_D4_LINK_PHASE 5'h01
`define TRX_ESF_LINK_PHASE 5'h00
`define TRX_SYNC_OE_RESET 1'b1
`define TRX_BUF_WIDTH 2
`define TRX_BUF_DEPTH 2
`endif

// file: verilog/trx_edge_sync.sv
// Purpose: Bring a pin into the core clock domain and find its rising edges.
// Assumes: The pin toggles much slower than the core clock.
// Notes: The edge costs two core cycles of latency after the pin moves.
module trx_edge_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic rise_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } trx_edge_type;

  trx_edge_type s_ff;
  trx_edge_type nxt_s;

  // The first stage feeds only the second stage, so metastability stays contained.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.meta = pin_i;
    nxt_s.sync = s_ff.meta;
    nxt_s.prev = s_ff.sync;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // A rise is the settled level high while the previous sample was low.
  assign rise_o = s_ff.sync & ~s_ff.prev;
endmodule

// file: verilog/trx_pkg.sv
// Purpose: Types of the receive system-side output block.
// Assumes: trx_defs.svh holds every number.
// Notes: The state struct is the whole register set of the top module apart from its reset synchroniser.
`include "trx_defs.svh"
package trx_pkg;
  typedef enum logic [1:0] {
    TRX_FMT_D4 = 2'b00,
    TRX_FMT_ESF = 2'b01,
    TRX_FMT_ZBTSI = 2'b10
  } trx_format_type;

  typedef enum logic {
    TRX_ST_ALIGN = 1'b0,
    TRX_ST_RUN = 1'b1
  } trx_run_type;

  typedef struct packed {
    logic es;
    trx_run_type st;
    trx_format_type fmt;
    logic msel;
    logic dbl;
    logic sin;
    logic sync_pend;
    logic [7:0] bit_cnt;
    logic [4:0] frame;
    logic framer_data;
    logic serial;
    logic sig;
    logic chclk;
    logic chblk;
    logic fpulse;
    logic mpulse;
    logic bsync;
    logic bsync_oe;
    logic link_data;
    logic link_clk;
  } trx_state_type;
endpackage

// file: verilog/trx_rx_system.sv
// Purpose: Receive system-side outputs: data, signaling, channel timing, syncs, link.
// Assumes: Core clock far faster than both sampled clocks; framer ports on core clock.
// Notes: Frame length is 193 bit times in both domains.
// Functional notes
// - Link data updates one bit before frame
// - Link clock 4kHz, 2kHz in ZBTSI
// - Framer side runs on core clock
// - Channel clock high on each channel LSB
// - Channel outputs follow the active clock domain
// - Channel block programmable per each channel
// - Serial data changes on active clock rise
// - Boundary sync marks frames or multiframes
// - Optional double-wide pulse on signaling frames
// - Boundary sync can become an input
// - Frame pulse one clock wide per frame
// - Multiframe pulse in backplane timing
// - Multiframe pulse in line timing
// - Framer data changes on line rise
// - Signaling output changes on active rise
`include "trx_defs.svh"
module trx_rx_system (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic recv_line_clk_i,
  input wire logic recv_backplane_clock_i,
  input wire logic recv_elastic_store_enable_i,
  input wire trx_pkg::trx_format_type recv_format_i,
  input wire logic sync_multiframe_select_i,
  input wire logic sync_double_wide_enable_i,
  input wire logic sync_input_enable_i,
  input wire logic [23:0] recv_channel_block_mask_i,
  input wire logic recv_framer_valid_i,
  input wire logic recv_framer_bit_i,
  input wire logic recv_framer_sig_i,
  input wire logic recv_link_bit_i,
  input wire logic recv_boundary_sync_i,
  output logic recv_framer_ready_o,
  output logic recv_framer_data_out_o,
  output logic recv_serial_out_o,
  output logic recv_signaling_out_o,
  output logic recv_channel_clock_out_o,
  output logic recv_channel_block_out_o,
  output logic recv_frame_pulse_o,
  output logic recv_multiframe_pulse_o,
  output logic recv_boundary_sync_o,
  output logic recv_boundary_sync_oe_o,
  output logic recv_link_data_out_o,
  output logic recv_link_clock_out_o
);
  import trx_pkg::*;

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;
  logic line_rise;
  logic bp_rise;
  logic sync_rise;
  logic tick;
  logic es_same;
  logic buf_pop;
  logic buf_valid;
  logic [1:0] buf_data;
  logic [31:0] mask_ext;
  trx_state_type s_ff;
  trx_state_type nxt_s;

  // Reset is applied at once but released only after two core edges.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  trx_edge_sync u_line_edge (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .pin_i(recv_line_clk_i),
    .rise_o(line_rise)
  );

  trx_edge_sync u_bp_edge (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .pin_i(recv_backplane_clock_i),
    .rise_o(bp_rise)
  );

  trx_edge_sync u_sync_edge (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .pin_i(recv_boundary_sync_i),
    .rise_o(sync_rise)
  );

  // The backplane clock is ignored entirely unless the elastic store is on.
  assign tick = s_ff.es ? bp_rise : line_rise;
  assign es_same = (recv_elastic_store_enable_i == s_ff.es);
  assign buf_pop = tick & buf_valid & es_same;
  assign mask_ext = {8'h00, recv_channel_block_mask_i};

  // The buffer absorbs a short backplane stall; once full, the framer is held off.
  trx_bit_buffer #(
    .WIDTH(`TRX_BUF_WIDTH),
    .DEPTH(`TRX_BUF_DEPTH)
  ) u_buf (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(recv_framer_valid_i),
    .in_data_i({recv_framer_sig_i, recv_framer_bit_i}),
    .in_ready_o(recv_framer_ready_o),
    .out_valid_o(buf_valid),
    .out_data_o(buf_data),
    .out_ready_i(buf_pop)
  );

  // Timing engine: the bit-time outputs are recomputed for the new bit time on each tick; framer data follows the line rise.
  always_comb begin
    logic [7:0] nb;
    logic [7:0] pos;
    logic [4:0] nf;
    logic [4:0] nnf;
    logic [4:0] last_f;
    logic [4:0] period;
    logic [4:0] phase;
    logic [4:0] m;
    logic sigf;
    nb = '0;
    pos = '0;
    nf = '0;
    nnf = '0;
    last_f = '0;
    period = '0;
    phase = '0;
    m = '0;
    sigf = 1'b0;
    nxt_s = s_ff;
    if (line_rise) begin
      nxt_s.framer_data = recv_framer_bit_i;
    end
    nxt_s.sin = s_ff.es & sync_input_enable_i;
    nxt_s.bsync_oe = ~(s_ff.es & sync_input_enable_i);
    if (sync_rise && s_ff.sin) begin
      nxt_s.sync_pend = 1'b1;
    end
    if (!es_same) begin
      // A domain change clears every output but framer data, link data and the sync enable, and restarts at a frame start.
      nxt_s.es = recv_elastic_store_enable_i;
      nxt_s.st = TRX_ST_ALIGN;
      nxt_s.bit_cnt = `TRX_LAST_BIT;
      nxt_s.frame = `TRX_ESF_LAST_FRAME;
      nxt_s.sync_pend = 1'b0;
      nxt_s.serial = 1'b0;
      nxt_s.sig = 1'b0;
      nxt_s.chclk = 1'b0;
      nxt_s.chblk = 1'b0;
      nxt_s.fpulse = 1'b0;
      nxt_s.mpulse = 1'b0;
      nxt_s.bsync = 1'b0;
      nxt_s.link_clk = 1'b0;
    end else if (tick) begin
      last_f = (s_ff.fmt == TRX_FMT_D4) ? `TRX_D4_LAST_FRAME : `TRX_ESF_LAST_FRAME;
      if (s_ff.bit_cnt >= `TRX_LAST_BIT) begin
        nb = `TRX_FBIT;
        nf = (s_ff.frame >= last_f) ? 5'h00 : 5'(s_ff.frame + 5'h01);
      end else begin
        nb = 8'(s_ff.bit_cnt + 8'h01);
        nf = s_ff.frame;
      end
      // An applied boundary pulse realigns the count at the next tick.
      if (s_ff.sync_pend) begin
        nb = `TRX_FBIT;
        if (s_ff.msel) begin
          nf = 5'h00;
        end
      end
      nxt_s.sync_pend = sync_rise & s_ff.sin;
      nxt_s.bit_cnt = nb;
      nxt_s.frame = nf;
      nxt_s.st = TRX_ST_RUN;
      // Options change only at a frame start, so a pulse is never cut short.
      if (nb == `TRX_FBIT) begin
        nxt_s.fmt = recv_format_i;
        nxt_s.msel = sync_multiframe_select_i;
        nxt_s.dbl = sync_double_wide_enable_i;
      end
      pos = 8'(nb - `TRX_FIRST_CHAN_BIT);
      nxt_s.chclk = (nb != `TRX_FBIT) && (nb[2:0] == `TRX_LSB_SLOT);
      nxt_s.chblk = (nb != `TRX_FBIT) && mask_ext[pos[7:3]];
      if (buf_valid) begin
        nxt_s.serial = buf_data[0];
        nxt_s.sig = buf_data[1];
      end
      nxt_s.fpulse = (nb == `TRX_FBIT);
      nxt_s.mpulse = (nb == `TRX_FBIT) && (nf == 5'h00);
      sigf = (nf == `TRX_SIG_FRAME_A) || (nf == `TRX_SIG_FRAME_B) ||
             (nf == `TRX_SIG_FRAME_C) || (nf == `TRX_SIG_FRAME_D);
      if (s_ff.sin) begin
        nxt_s.bsync = 1'b0;
      end else if (nxt_s.msel) begin
        nxt_s.bsync = nxt_s.mpulse;
      end else begin
        nxt_s.bsync = nxt_s.fpulse ||
                      (nxt_s.dbl && sigf && (nb == `TRX_FIRST_CHAN_BIT));
      end
      // The link bit for the next frame is presented during the last bit time.
      if (nb == `TRX_LAST_BIT) begin
        nnf = (nf >= last_f) ? 5'h00 : 5'(nf + 5'h01);
        period = (s_ff.fmt == TRX_FMT_ZBTSI) ? `TRX_ZBTSI_LINK_FRAMES : `TRX_LINK_FRAMES;
        phase = (s_ff.fmt == TRX_FMT_D4) ? `TRX_D4_LINK_PHASE : `TRX_ESF_LINK_PHASE;
        m = 5'(nnf - phase) & 5'(period - 5'h01);
        if (m == 5'h00) begin
          nxt_s.link_data = recv_link_bit_i;
        end
        nxt_s.link_clk = (m < (period >> 1));
      end
    end
    // A pin turned input must not keep a stale output pulse behind its enable.
    if (nxt_s.sin) begin
      nxt_s.bsync = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.bit_cnt <= `TRX_LAST_BIT;
      s_ff.frame <= `TRX_ESF_LAST_FRAME;
      s_ff.bsync_oe <= `TRX_SYNC_OE_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Every output but the framer ready is a field of the registered state.
  assign recv_framer_data_out_o = s_ff.framer_data;
  assign recv_serial_out_o = s_ff.serial;
  assign recv_signaling_out_o = s_ff.sig;
  assign recv_channel_clock_out_o = s_ff.chclk;
  assign recv_channel_block_out_o = s_ff.chblk;
  assign recv_frame_pulse_o = s_ff.fpulse;
  assign recv_multiframe_pulse_o = s_ff.mpulse;
  assign recv_boundary_sync_o = s_ff.bsync;
  assign recv_boundary_sync_oe_o = s_ff.bsync_oe;
  assign recv_link_data_out_o = s_ff.link_data;
  assign recv_link_clock_out_o = s_ff.link_clk;

  // Checks on the timing engine.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  link_update_a: assert property ($changed(s_ff.link_data) |-> s_ff.bit_cnt == `TRX_LAST_BIT)
    else $error("link data changed outside the last bit time");
  link_zbtsi_a: assert property (s_ff.st == TRX_ST_RUN && s_ff.fmt == TRX_FMT_ZBTSI
    && s_ff.bit_cnt == `TRX_LAST_BIT && $changed(s_ff.bit_cnt)
    |-> s_ff.link_clk == (s_ff.frame[1:0] == 2'b11 || s_ff.frame[1:0] == 2'b00))
    else $error("ZBTSI link clock wrong at the last bit time");
  line_step_a: assert property (!s_ff.es && $past(es_same) && $changed(s_ff.bit_cnt)
    |-> $past(line_rise))
    else $error("line timing stepped without a line clock rise");
  chan_lsb_a: assert property (s_ff.chclk |-> s_ff.bit_cnt != `TRX_FBIT
    && s_ff.bit_cnt[2:0] == `TRX_LSB_SLOT)
    else $error("channel clock high outside an LSB");
  out_timing_a: assert property ($changed({s_ff.serial, s_ff.sig, s_ff.chclk, s_ff.chblk})
    |-> $past(tick) || $changed(s_ff.es))
    else $error("output changed off the active clock");
  frame_pos_a: assert property (s_ff.fpulse |-> s_ff.bit_cnt == `TRX_FBIT)
    else $error("frame pulse away from the F bit");
  frame_width_a: assert property (s_ff.fpulse && tick && !s_ff.sync_pend && es_same
    |=> !s_ff.fpulse)
    else $error("frame pulse wider than one clock");
  mframe_pos_a: assert property (s_ff.mpulse |-> s_ff.fpulse && s_ff.frame == 5'h00)
    else $error("multiframe pulse off the multiframe start");
  bsync_sel_a: assert property (s_ff.st == TRX_ST_RUN && !s_ff.sin
    && (s_ff.msel || !s_ff.dbl)
    |-> s_ff.bsync == (s_ff.msel ? s_ff.mpulse : s_ff.fpulse))
    else $error("boundary sync disagrees with its selection");
  bsync_dbl_a: assert property (!s_ff.sin && s_ff.dbl && !s_ff.msel
    && s_ff.bit_cnt == `TRX_FIRST_CHAN_BIT && s_ff.frame == `TRX_SIG_FRAME_B |-> s_ff.bsync)
    else $error("double-wide pulse missing on a signaling frame");
  sync_dir_a: assert property (s_ff.sin |-> !s_ff.bsync_oe && !s_ff.bsync)
    else $error("boundary sync driven while it is an input");
  framer_edge_a: assert property ($changed(s_ff.framer_data) |-> $past(line_rise))
    else $error("framer data changed without a line clock rise");
  domain_sw_a: assert property ($changed(s_ff.es) |-> !s_ff.fpulse && !s_ff.chclk
    && s_ff.st == TRX_ST_ALIGN)
    else $error("outputs not cleared on a domain change");

  bp_frame_c: cover property (s_ff.es && s_ff.fpulse);
  line_mframe_c: cover property (!s_ff.es && s_ff.mpulse);
  sync_align_c: cover property (s_ff.sync_pend && tick);
  buf_stall_c: cover property (!recv_framer_ready_o && recv_framer_valid_i);
endmodule
